// [design/pscf_pkg.sv]
// Package for the performance-state control and activity counter block
package pscf_pkg;
  localparam logic [31:0] ADDR_REF_CNT = 32'h0000_00e7;
  localparam logic [31:0] ADDR_ACT_CNT = 32'h0000_00e8;
  localparam logic [31:0] ADDR_TGT_CTL = 32'h0000_0199;
  localparam logic [31:0] ADDR_CUR_STS = 32'h0000_0198;
  localparam logic [31:0] ADDR_MISC_EN = 32'h0000_01a0;
  localparam int MISC_PST_EN_BIT = 16;
  localparam int FEAT_PST_BIT = 7;
  localparam int LEAF6_FEEDBACK_BIT = 0;
  localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
  localparam logic [31:0] LEAF_POWER = 32'h0000_0006;
  localparam logic [63:0] MISC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] OP_RESET = 16'h0000;
  localparam logic [63:0] CNT_RESET = 64'h0000_0000_0000_0000;
  // Countdown loaded per one-code step of the operating point; a step lasts this many cycles plus one
  localparam logic [7:0] STEP_CYCLES = 8'h04;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } pscf_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [63:0] rdata;
  } pscf_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_STEP = 3'b100
  } pscf_state_t;
endpackage

// [design/pscf_counter.sv]
// One 64-bit feedback counter with software write and shared clear
`timescale 1ns/1ps
`default_nettype none
module pscf_counter import pscf_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic clr,
  input wire logic wr,
  input wire logic [63:0] wdata,
  // State
  output logic [63:0] count,
  output logic wrap
);
  logic [63:0] cnt_q;
  logic [63:0] cnt_d;

  assign count = cnt_q;
  assign wrap = inc && (cnt_q == 64'hffff_ffff_ffff_ffff);

  always_comb begin
    cnt_d = cnt_q;
    if (wr) begin
      cnt_d = wdata;
    end else if (clr) begin
      cnt_d = CNT_RESET;
    end else if (inc) begin
      cnt_d = cnt_q + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// [design/pscf_top.sv]
// Performance-state target/status registers and activity feedback counters
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Feature query reports transition support bit 7
// - Transitions start only while enable bit 16 set
// - Writing 16-bit target starts a transition
// - Newer target accepted mid-transition, followed later
// - Target read returns last written value
// - Status always shows point in effect
// - Operating-point code meaning is model specific
// - Leaf six reports counters present bit 0
// - Reference counter ticks at fixed rate
// - Delivered counter ticks with actual performance
// - Counters advance only while processor active
// - Either overflow clears both counters together; a counter written in the same cycle takes the write
// - Counters 64-bit, each writable independently
module pscf_top import pscf_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Model register access
  input wire pscf_req_t req,
  output pscf_rsp_t rsp,
  // Feature query
  input wire logic query_valid,
  input wire logic [31:0] query_leaf,
  output logic [31:0] query_ecx,
  // Core activity and throttling
  input wire logic core_active,
  input wire logic ref_tick,
  input wire logic perf_tick,
  // Operating point actuation view
  output logic [15:0] op_point,
  output logic pst_enable
);
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Input synchronisers for core-side levels
  logic [2:0] in_s1_q;
  logic [2:0] in_s2_q;
  logic [2:0] in_prev_q;
  // Marks stages that hold real pin levels since reset
  logic [2:0] prime_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= 3'b000;
      in_s2_q <= 3'b000;
      in_prev_q <= 3'b000;
      prime_q <= 3'b000;
    end else begin
      in_s1_q <= {core_active, ref_tick, perf_tick};
      in_s2_q <= in_s1_q;
      in_prev_q <= in_s2_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  logic active;
  logic ref_ev;
  logic perf_ev;
  assign active = in_s2_q[2];
  // Tick inputs are toggles; one event per edge
  // No event until both compared stages hold pin levels, so a tick pin
  // left high across reset does not count a false edge
  assign ref_ev = active && prime_q[2] && (in_s2_q[1] ^ in_prev_q[1]);
  assign perf_ev = active && prime_q[2] && (in_s2_q[0] ^ in_prev_q[0]);

  // Register write decode
  logic wr_ref;
  logic wr_act;
  logic wr_tgt;
  logic wr_misc;
  assign wr_ref = req.wr && (req.addr == ADDR_REF_CNT);
  assign wr_act = req.wr && (req.addr == ADDR_ACT_CNT);
  assign wr_tgt = req.wr && (req.addr == ADDR_TGT_CTL);
  assign wr_misc = req.wr && (req.addr == ADDR_MISC_EN);

  // Feedback counters
  logic [63:0] ref_cnt;
  logic [63:0] act_cnt;
  logic ref_wrap;
  logic act_wrap;
  logic any_wrap;
  assign any_wrap = ref_wrap || act_wrap;

  pscf_counter u_ref (
    .clk(clk),
    .rst_n(rst_n),
    .inc(ref_ev),
    .clr(any_wrap),
    .wr(wr_ref),
    .wdata(req.wdata),
    .count(ref_cnt),
    .wrap(ref_wrap)
  );

  pscf_counter u_act (
    .clk(clk),
    .rst_n(rst_n),
    .inc(perf_ev),
    .clr(any_wrap),
    .wr(wr_act),
    .wdata(req.wdata),
    .count(act_cnt),
    .wrap(act_wrap)
  );

  // Control registers and transition engine
  logic [63:0] misc_q;
  logic [63:0] misc_d;
  logic [15:0] tgt_q;
  logic [15:0] tgt_d;
  logic [15:0] cur_q;
  logic [15:0] cur_d;
  logic [7:0] step_q;
  logic [7:0] step_d;
  logic pend_q;
  logic pend_d;
  pscf_state_t st_q;
  pscf_state_t st_d;

  always_comb begin
    misc_d = misc_q;
    tgt_d = tgt_q;
    cur_d = cur_q;
    step_d = step_q;
    pend_d = pend_q;
    st_d = st_q;
    if (wr_misc) begin
      misc_d = req.wdata;
    end
    if (wr_tgt) begin
      tgt_d = req.wdata[15:0];
      pend_d = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (pend_q && misc_q[MISC_PST_EN_BIT]) begin
          st_d = ST_STEP;
          step_d = STEP_CYCLES;
          if (!wr_tgt) begin
            pend_d = 1'b0;
          end
        end
      end
      ST_STEP: begin
        if (step_q != 8'h00) begin
          step_d = step_q - 8'h01;
        end else if (cur_q == tgt_q) begin
          st_d = ST_WAIT;
        end else begin
          // One code per step; the newest target is chased
          cur_d = (cur_q < tgt_q) ? cur_q + 16'h0001 : cur_q - 16'h0001;
          step_d = STEP_CYCLES;
        end
      end
      ST_WAIT: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_q <= MISC_RESET;
      tgt_q <= OP_RESET;
      cur_q <= OP_RESET;
      step_q <= 8'h00;
      pend_q <= 1'b0;
      st_q <= ST_IDLE;
    end else begin
      misc_q <= misc_d;
      tgt_q <= tgt_d;
      cur_q <= cur_d;
      step_q <= step_d;
      pend_q <= pend_d;
      st_q <= st_d;
    end
  end

  // Read mux and query answers
  pscf_rsp_t rsp_d;
  logic [31:0] ecx_d;
  always_comb begin
    rsp_d.ack = req.rd || req.wr;
    rsp_d.err = 1'b0;
    rsp_d.rdata = 64'h0000_0000_0000_0000;
    unique case (req.addr)
      ADDR_REF_CNT: rsp_d.rdata = ref_cnt;
      ADDR_ACT_CNT: rsp_d.rdata = act_cnt;
      ADDR_TGT_CTL: rsp_d.rdata = {48'h0000_0000_0000, tgt_q};
      ADDR_CUR_STS: rsp_d.rdata = {48'h0000_0000_0000, cur_q};
      ADDR_MISC_EN: rsp_d.rdata = misc_q;
      default: rsp_d.err = req.rd || req.wr;
    endcase
    if (!req.rd) begin
      rsp_d.rdata = 64'h0000_0000_0000_0000;
    end
    ecx_d = 32'h0000_0000;
    if (query_valid && query_leaf == LEAF_BASIC) begin
      ecx_d[FEAT_PST_BIT] = 1'b1;
    end
    if (query_valid && query_leaf == LEAF_POWER) begin
      ecx_d[LEAF6_FEEDBACK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
      query_ecx <= 32'h0000_0000;
      op_point <= OP_RESET;
      pst_enable <= 1'b0;
    end else begin
      rsp <= rsp_d;
      query_ecx <= ecx_d;
      op_point <= cur_q;
      pst_enable <= misc_q[MISC_PST_EN_BIT];
    end
  end

  a_both_clear: assert property (@(posedge clk) disable iff (!rst_n)
    any_wrap && !wr_ref && !wr_act |=> (ref_cnt == 64'h0) && (act_cnt == 64'h0))
    else $error("counters not cleared together on overflow");
  a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !active && !wr_ref && !wr_act |=> $stable(ref_cnt) && $stable(act_cnt))
    else $error("counter moved while inactive");
  a_ref_inc: assert property (@(posedge clk) disable iff (!rst_n)
    ref_ev && !any_wrap && !wr_ref |=> ref_cnt == $past(ref_cnt) + 64'h1)
    else $error("reference counter did not step");
  a_act_inc: assert property (@(posedge clk) disable iff (!rst_n)
    perf_ev && !any_wrap && !wr_act |=> act_cnt == $past(act_cnt) + 64'h1)
    else $error("delivered counter did not step");
  a_write_indep: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ref && !wr_act && !any_wrap |=> act_cnt == $past(act_cnt) + {63'h0, $past(perf_ev)})
    else $error("reference write disturbed delivered counter");
  a_tgt_read: assert property (@(posedge clk) disable iff (!rst_n)
    wr_tgt ##1 (req.rd && req.addr == ADDR_TGT_CTL && !wr_tgt)
      |=> rsp.rdata[15:0] == $past(req.wdata[15:0], 2))
    else $error("target readback wrong");
  a_no_move_dis: assert property (@(posedge clk) disable iff (!rst_n)
    !misc_q[MISC_PST_EN_BIT] && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("transition started while disabled");
  a_step_one: assert property (@(posedge clk) disable iff (!rst_n)
    cur_q != $past(cur_q) |-> (cur_q == $past(cur_q) + 16'h1 || cur_q == $past(cur_q) - 16'h1))
    else $error("status jumped more than one code");
  a_feat_bits: assert property (@(posedge clk) disable iff (!rst_n)
    query_valid && query_leaf == LEAF_POWER |=> query_ecx[0])
    else $error("feedback counters not reported");
  a_pst_feat: assert property (@(posedge clk) disable iff (!rst_n)
    query_valid && query_leaf == LEAF_BASIC |=> query_ecx[7])
    else $error("transition support not reported");
  a_reach_tgt: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_STEP && step_q == 8'h00 && cur_q == tgt_q && !wr_tgt |=> st_q == ST_WAIT)
    else $error("transition did not finish at target");

  // Register answers, transition engine and mirrored outputs
  a_ack_follow: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd || req.wr |=> rsp.ack)
    else $error("request not acknowledged");
  a_ack_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !req.rd && !req.wr |=> !rsp.ack)
    else $error("acknowledge without request");
  a_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_CUR_STS |=> rsp.rdata == {48'h0000_0000_0000, $past(cur_q)})
    else $error("status read not point in effect");
  a_ref_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_REF_CNT |=> rsp.rdata == $past(ref_cnt))
    else $error("reference counter read wrong");
  a_act_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_ACT_CNT |=> rsp.rdata == $past(act_cnt))
    else $error("delivered counter read wrong");
  a_start_step: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_IDLE && pend_q && misc_q[MISC_PST_EN_BIT] |=> st_q == ST_STEP)
    else $error("pending target did not start");
  a_cur_hold: assert property (@(posedge clk) disable iff (!rst_n)
    st_q != ST_STEP |=> cur_q == $past(cur_q))
    else $error("status moved outside a step");
  a_op_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> op_point == $past(cur_q))
    else $error("operating point output stale");
  a_en_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> pst_enable == $past(misc_q[MISC_PST_EN_BIT]))
    else $error("enable output does not follow bit");
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the performance-state control and feedback counter block
`timescale 1ns/1ps
`default_nettype none
module tb import pscf_pkg::*;;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic err;
  } pscf_row_t;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  pscf_req_t req = '0;
  pscf_rsp_t rsp;
  logic query_valid = 1'b0;
  logic [31:0] query_leaf = 32'h0000_0000;
  logic [31:0] query_ecx;
  logic core_active = 1'b0;
  logic ref_tick = 1'b0;
  logic perf_tick = 1'b0;
  logic [15:0] op_point;
  logic pst_enable;
  logic [63:0] rdata_seen;
  logic err_seen;
  int n_mismatch = 0;
  int comparisons = 0;

  // Reads give zero data on writes; unmapped places answer with err
  pscf_row_t rows [12] = '{
    '{1'b0, ADDR_MISC_EN, 64'h0, 64'h0, 1'b0},
    '{1'b0, ADDR_TGT_CTL, 64'h0, 64'h0, 1'b0},
    '{1'b0, ADDR_CUR_STS, 64'h0, 64'h0, 1'b0},
    '{1'b1, ADDR_TGT_CTL, 64'hffff_0000_0000_1234, 64'h0, 1'b0},
    '{1'b0, ADDR_TGT_CTL, 64'h0, 64'h0000_0000_0000_1234, 1'b0},
    '{1'b1, ADDR_TGT_CTL, 64'h0, 64'h0, 1'b0},
    '{1'b1, ADDR_REF_CNT, 64'h0123_4567_89ab_cdef, 64'h0, 1'b0},
    '{1'b0, ADDR_REF_CNT, 64'h0, 64'h0123_4567_89ab_cdef, 1'b0},
    '{1'b0, ADDR_ACT_CNT, 64'h0, 64'h0, 1'b0},
    '{1'b0, 32'h0000_0010, 64'h0, 64'h0, 1'b1},
    '{1'b1, 32'h0000_0010, 64'h5, 64'h0, 1'b1},
    '{1'b1, ADDR_REF_CNT, 64'h0, 64'h0, 1'b0}
  };

  always #50 clk = ~clk;

  pscf_top uut (
    .clk(clk), .nrst(nrst), .req(req), .rsp(rsp),
    .query_valid(query_valid), .query_leaf(query_leaf), .query_ecx(query_ecx),
    .core_active(core_active), .ref_tick(ref_tick), .perf_tick(perf_tick),
    .op_point(op_point), .pst_enable(pst_enable)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // One register access; ack lands on the edge that takes the request
  task automatic access(input logic wr, input logic [31:0] addr, input logic [63:0] wdata);
    wait_cyc(1);
    req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    wait_cyc(1);
    req = '0;
    check(64'(rsp.ack), 64'h1);
    rdata_seen = rsp.rdata;
    err_seen = rsp.err;
  endtask

  task automatic tick(input logic use_ref, input int n);
    repeat (n) begin
      wait_cyc(1);
      if (use_ref) ref_tick = ~ref_tick;
      else perf_tick = ~perf_tick;
      wait_cyc(3);
    end
  endtask

  task automatic query(input logic [31:0] leaf, input logic [31:0] exp);
    wait_cyc(1);
    query_valid = 1'b1;
    query_leaf = leaf;
    wait_cyc(1);
    check(64'(query_ecx), 64'(exp));
    query_valid = 1'b0;
  endtask

  task automatic wait_op(input logic [15:0] val);
    for (int i = 0; i < 80 && op_point !== val; i++) wait_cyc(1);
    check(64'(op_point), 64'(val));
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #10;
    nrst = 1'b1;
    wait_cyc(4);
    check(64'(pst_enable), 64'h0);
    foreach (rows[k]) begin
      access(rows[k].wr, rows[k].addr, rows[k].wdata);
      check(rdata_seen, rows[k].rdata);
      check(64'(err_seen), 64'(rows[k].err));
    end
    query(LEAF_BASIC, 32'h0000_0080);
    query(LEAF_POWER, 32'h0000_0001);
    query(32'h0000_0002, 32'h0000_0000);
    // Feedback counters: active counting, holding, overflow clear
    core_active = 1'b1;
    wait_cyc(3);
    tick(1'b1, 3);
    tick(1'b0, 2);
    access(1'b0, ADDR_REF_CNT, 64'h0);
    check(rdata_seen, 64'h3);
    access(1'b0, ADDR_ACT_CNT, 64'h0);
    check(rdata_seen, 64'h2);
    core_active = 1'b0;
    wait_cyc(3);
    tick(1'b1, 2);
    tick(1'b0, 2);
    access(1'b0, ADDR_REF_CNT, 64'h0);
    check(rdata_seen, 64'h3);
    core_active = 1'b1;
    wait_cyc(3);
    access(1'b1, ADDR_REF_CNT, 64'hffff_ffff_ffff_ffff);
    access(1'b1, ADDR_ACT_CNT, 64'h0000_0000_0000_0005);
    tick(1'b1, 1);
    access(1'b0, ADDR_REF_CNT, 64'h0);
    check(rdata_seen, 64'h0);
    access(1'b0, ADDR_ACT_CNT, 64'h0);
    check(rdata_seen, 64'h0);
    tick(1'b0, 1);
    access(1'b0, ADDR_ACT_CNT, 64'h0);
    check(rdata_seen, 64'h1);
    // Transitions: held off while disabled, retargeted mid-move
    access(1'b1, ADDR_TGT_CTL, 64'h3);
    wait_cyc(30);
    check(64'(op_point), 64'h0);
    access(1'b1, ADDR_MISC_EN, 64'h0000_0000_0001_0000);
    wait_cyc(2);
    check(64'(pst_enable), 64'h1);
    wait_op(16'h0003);
    // Write then read of the target on consecutive edges
    wait_cyc(1);
    req = '{rd: 1'b0, wr: 1'b1, addr: ADDR_TGT_CTL, wdata: 64'h0000_0000_0000_0006};
    wait_cyc(1);
    check(64'(rsp.ack), 64'h1);
    req = '{rd: 1'b1, wr: 1'b0, addr: ADDR_TGT_CTL, wdata: 64'h0000_0000_0000_0000};
    wait_cyc(1);
    req = '0;
    check(64'(rsp.ack), 64'h1);
    check(rsp.rdata, 64'h6);
    access(1'b0, ADDR_CUR_STS, 64'h0);
    check(64'(rdata_seen[15:0] < 16'h0006), 64'h1);
    wait_cyc(5);
    access(1'b1, ADDR_TGT_CTL, 64'h4);
    wait_cyc(40);
    check(64'(op_point), 64'h4);
    access(1'b0, ADDR_CUR_STS, 64'h0);
    check(rdata_seen, 64'h4);
    access(1'b1, ADDR_MISC_EN, 64'h0);
    access(1'b1, ADDR_TGT_CTL, 64'h7);
    wait_cyc(30);
    check(64'(op_point), 64'h4);
    access(1'b1, ADDR_MISC_EN, 64'h0000_0000_0001_0000);
    wait_op(16'h0007);
    // Reset in mid-run clears the enable again
    nrst = 1'b0;
    wait_cyc(2);
    check(64'(pst_enable), 64'h0);
    nrst = 1'b1;
    wait_cyc(4);
    access(1'b0, ADDR_MISC_EN, 64'h0);
    check(rdata_seen, 64'h0);
    // Delivered tick pin is high here; no false count after reset
    access(1'b0, ADDR_ACT_CNT, 64'h0);
    check(rdata_seen, 64'h0);
    wrap_up();
  end

  initial begin
    #200_000;
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
